// [core/hdpsl_defines.svh]
// constants of the half-duplex polled slave link engine
`ifndef HDPSL_DEFINES_SVH
`define HDPSL_DEFINES_SVH

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define HDPSL_CLK_HZ       100000000
`define HDPSL_MS_PER_S     1000
`define HDPSL_TICK_MS      1
`define HDPSL_SLOW_UNIT_MS 20

// -----------------------------------------------------------------------
// addresses on the link
// -----------------------------------------------------------------------
`define HDPSL_BCAST_ADDR   8'hFF
`define HDPSL_ADDR_RST     8'h01

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define HDPSL_OFS_CTRL     8'h00
`define HDPSL_OFS_ADDR     8'h01
`define HDPSL_OFS_POLLTO   8'h02
`define HDPSL_OFS_OFFDLY   8'h03
`define HDPSL_OFS_SENDDLY  8'h04
`define HDPSL_OFS_PREDLY   8'h05
`define HDPSL_OFS_RETRY    8'h06
`define HDPSL_OFS_STATUS   8'h07
`define HDPSL_OFS_SENT     8'h0A
`define HDPSL_OFS_RCVD     8'h0B
`define HDPSL_OFS_NAK      8'h0E
`define HDPSL_OFS_POLLS    8'h0F
`define HDPSL_OFS_NOBUF    8'h11

// -----------------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------------
`define HDPSL_CTRL_DUP     0
`define HDPSL_CTRL_EOTSUP  1
`define HDPSL_CTRL_MODEM   2
`define HDPSL_STAT_ERR     0
`define HDPSL_STAT_TMO     1
`define HDPSL_STAT_QUEUED  2
`define HDPSL_STAT_RTS     3
`define HDPSL_STAT_CTS     4
`define HDPSL_CTRL_RST     3'h0
`define HDPSL_DLY_RST      16'h0000
`define HDPSL_RETRY_RST    8'h03

`endif

// [core/hdpsl_pkg.sv]
// types of the half-duplex polled slave link engine
package hdpsl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_RTS_ON, ST_SEND, ST_RTS_OFF, ST_WAIT_ACK
  } hdpsl_state_t;

  typedef enum logic [1:0] {
    KIND_ACK, KIND_EOT, KIND_MSG
  } hdpsl_kind_t;

endpackage : hdpsl_pkg

// [core/hdpsl_link.sv]
// link-layer engine of a polled half-duplex slave station
// What this block does
// - duplicate detect on: acknowledge repeat of last message, do not execute
// - duplicate detect off: execute every repeat like a new command
// - poll timer starts when a slave-initiated message is queued
// - poll timer expires first: set error flag, drop queued message
// - message timeout expires first: set error and timeout flags
// - poll timeout of zero disables the poll timer
// - after the last character wait off delay (20 ms units), then drop RTS
// - after raising RTS wait send delay (20 ms units) before first character
// - in modem mode characters go out only while clear-to-send is high
// - resend unacknowledged message up to retry count, then undeliverable
// - wait pre-transmit delay (1 ms units) before raising RTS
// - suppression on: send nothing to a poll when no data is held
// - suppression off: answer a poll without data by an EOT packet
// - poll timer applies only to slave-initiated messages, not replies
// - slave-initiated message stays queued until the master polls
// - sent counter counts every message transmitted, retries included
// - received counter counts each message received without error
// - poll counter counts each poll packet received for this station's address
// - nak counter counts each NAK received
// - no-buffer counter counts messages lost for lack of buffer space
// - station address 0 to 254; 255 is broadcast and never assigned
// - control-line mode selects no handshaking or RTS/CTS modem operation
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "hdpsl_defines.svh"

module hdpsl_link #(
  parameter int TICK_CYCLES = `HDPSL_CLK_HZ / `HDPSL_MS_PER_S * `HDPSL_TICK_MS,
  parameter int CNT_W       = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic [15:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [15:0]        regRdata,
  // events from the packet decoder
  input  wire logic               rxMsgValid,
  input  wire logic [7:0]         rxMsgAddr,
  input  wire logic [15:0]        rxMsgSig,
  input  wire logic               rxBufFull,
  input  wire logic               rxPollValid,
  input  wire logic [7:0]         rxPollAddr,
  input  wire logic               rxAckValid,
  input  wire logic               rxNakValid,
  // message sources
  input  wire logic               replyReady,
  input  wire logic               slvMsgReq,
  input  wire logic               msgTimeoutHit,
  // transmitter and modem
  input  wire logic               cts,
  input  wire logic               txDone,
  output logic                    txEnable,
  output hdpsl_pkg::hdpsl_kind_t  txKind,
  output logic                    rts,
  // results
  output logic                    cmdExecute,
  output logic                    msgAcked,
  output logic                    msgUndeliverable,
  output logic                    msgFromSlave,
  output logic                    msgError,
  output logic                    msgTimeout
);
  import hdpsl_pkg::*;

  function automatic logic [20:0] toMs(input logic [15:0] v,
                                       input logic slow);
    toMs = slow ? 21'(v) * 21'(`HDPSL_SLOW_UNIT_MS) : 21'(v);
  endfunction : toMs

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  logic [2:0]  ctrl,      next_ctrl;
  logic [7:0]  stnAddr,   next_stnAddr;
  logic [15:0] pollTo,    next_pollTo;
  logic [15:0] offDly,    next_offDly;
  logic [15:0] sendDly,   next_sendDly;
  logic [15:0] preDly,    next_preDly;
  logic [7:0]  retries,   next_retries;
  logic        dupOn, eotSup, modemOn;

  assign dupOn   = ctrl[`HDPSL_CTRL_DUP];
  assign eotSup  = ctrl[`HDPSL_CTRL_EOTSUP];
  assign modemOn = ctrl[`HDPSL_CTRL_MODEM];

  always_comb begin
    next_ctrl    = ctrl;
    next_stnAddr = stnAddr;
    next_pollTo  = pollTo;
    next_offDly  = offDly;
    next_sendDly = sendDly;
    next_preDly  = preDly;
    next_retries = retries;
    if (regWr) begin
      unique case (regAddr)
        `HDPSL_OFS_CTRL:    next_ctrl = regWdata[2:0];
        `HDPSL_OFS_ADDR:
          if (regWdata[7:0] != `HDPSL_BCAST_ADDR) begin
            next_stnAddr = regWdata[7:0];
          end
        `HDPSL_OFS_POLLTO:  next_pollTo  = regWdata;
        `HDPSL_OFS_OFFDLY:  next_offDly  = regWdata;
        `HDPSL_OFS_SENDDLY: next_sendDly = regWdata;
        `HDPSL_OFS_PREDLY:  next_preDly  = regWdata;
        `HDPSL_OFS_RETRY:   next_retries = regWdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl    <= `HDPSL_CTRL_RST;
      stnAddr <= `HDPSL_ADDR_RST;
      pollTo  <= `HDPSL_DLY_RST;
      offDly  <= `HDPSL_DLY_RST;
      sendDly <= `HDPSL_DLY_RST;
      preDly  <= `HDPSL_DLY_RST;
      retries <= `HDPSL_RETRY_RST;
    end else begin
      ctrl    <= next_ctrl;
      stnAddr <= next_stnAddr;
      pollTo  <= next_pollTo;
      offDly  <= next_offDly;
      sendDly <= next_sendDly;
      preDly  <= next_preDly;
      retries <= next_retries;
    end
  end

  // -----------------------------------------------------------------------
  // millisecond tick
  // -----------------------------------------------------------------------
  logic [TICK_W-1:0] tickCnt, next_tickCnt;
  logic              tick;

  assign tick = (tickCnt == TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    next_tickCnt = tick ? '0 : tickCnt + TICK_W'(1);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // -----------------------------------------------------------------------
  // receive side decode
  // -----------------------------------------------------------------------
  logic [15:0] lastSig,   next_lastSig;
  logic        lastValid, next_lastValid;
  logic        next_cmdExecute;
  logic        forUs, addrOk, rxGood, isDup, pollHit;

  assign forUs   = (rxMsgAddr == stnAddr);
  assign addrOk  = forUs || (rxMsgAddr == `HDPSL_BCAST_ADDR);
  assign rxGood  = rxMsgValid && addrOk && !rxBufFull;
  assign isDup   = lastValid && (rxMsgSig == lastSig);
  assign pollHit = rxPollValid && (rxPollAddr == stnAddr);

  always_comb begin
    next_lastSig    = lastSig;
    next_lastValid  = lastValid;
    next_cmdExecute = 1'b0;
    if (rxGood) begin
      next_lastSig    = rxMsgSig;
      next_lastValid  = 1'b1;
      next_cmdExecute = !(dupOn && isDup);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lastSig    <= '0;
      lastValid  <= 1'b0;
      cmdExecute <= 1'b0;
    end else begin
      lastSig    <= next_lastSig;
      lastValid  <= next_lastValid;
      cmdExecute <= next_cmdExecute;
    end
  end

  // -----------------------------------------------------------------------
  // transmit sequencer
  // -----------------------------------------------------------------------
  hdpsl_state_t state, next_state;
  hdpsl_kind_t  next_txKind;
  logic [20:0]  msCnt, next_msCnt;
  logic [7:0]   retryCnt, next_retryCnt;
  logic         next_rts, next_msgFromSlave;
  logic         next_msgAcked, next_msgUndeliverable;
  logic         slvQueued;
  logic         retryNow;

  assign txEnable = (state == ST_SEND) && (!modemOn || cts);
  assign retryNow = rxNakValid || pollHit;

  always_comb begin
    next_state            = state;
    next_txKind           = txKind;
    next_rts              = rts;
    next_msgFromSlave     = msgFromSlave;
    next_retryCnt         = retryCnt;
    next_msgAcked         = 1'b0;
    next_msgUndeliverable = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_retryCnt = '0;
        if (rxGood && forUs) begin
          next_txKind = KIND_ACK;
          next_state  = ST_PRE;
        end else if (pollHit) begin
          if (replyReady) begin
            next_txKind       = KIND_MSG;
            next_msgFromSlave = 1'b0;
            next_state        = ST_PRE;
          end else if (slvQueued) begin
            next_txKind       = KIND_MSG;
            next_msgFromSlave = 1'b1;
            next_state        = ST_PRE;
          end else if (!eotSup) begin
            next_txKind = KIND_EOT;
            next_state  = ST_PRE;
          end
        end
      end
      ST_PRE:
        if (msCnt >= toMs(preDly, 1'b0)) begin
          if (modemOn) begin
            next_rts   = 1'b1;
            next_state = ST_RTS_ON;
          end else begin
            next_state = ST_SEND;
          end
        end
      ST_RTS_ON:
        if (msCnt >= toMs(sendDly, 1'b1)) begin
          next_state = ST_SEND;
        end
      ST_SEND:
        if (txDone) begin
          if (modemOn) begin
            next_state = ST_RTS_OFF;
          end else begin
            next_state = (txKind == KIND_MSG) ? ST_WAIT_ACK : ST_IDLE;
          end
        end
      ST_RTS_OFF:
        if (msCnt >= toMs(offDly, 1'b1)) begin
          next_rts   = 1'b0;
          next_state = (txKind == KIND_MSG) ? ST_WAIT_ACK : ST_IDLE;
        end
      ST_WAIT_ACK:
        if (rxAckValid) begin
          next_msgAcked = 1'b1;
          next_state    = ST_IDLE;
        end else if (retryNow) begin
          if (retryCnt < retries) begin
            next_retryCnt = retryCnt + 8'(1);
            next_state    = ST_PRE;
          end else begin
            next_msgUndeliverable = 1'b1;
            next_state            = ST_IDLE;
          end
        end
      default: next_state = ST_IDLE;
    endcase
    if (next_state != state) begin
      next_msCnt = '0;
    end else begin
      next_msCnt = msCnt + 21'(tick);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state            <= ST_IDLE;
      txKind           <= KIND_ACK;
      rts              <= 1'b0;
      msgFromSlave     <= 1'b0;
      retryCnt         <= '0;
      msCnt            <= '0;
      msgAcked         <= 1'b0;
      msgUndeliverable <= 1'b0;
    end else begin
      state            <= next_state;
      txKind           <= next_txKind;
      rts              <= next_rts;
      msgFromSlave     <= next_msgFromSlave;
      retryCnt         <= next_retryCnt;
      msCnt            <= next_msCnt;
      msgAcked         <= next_msgAcked;
      msgUndeliverable <= next_msgUndeliverable;
    end
  end

  // -----------------------------------------------------------------------
  // slave message queue, poll timer and error flags
  // -----------------------------------------------------------------------
  logic [20:0] pollMs, next_pollMs;
  logic        next_slvQueued, next_msgError, next_msgTimeout;
  logic        serving, pollExp, statWr;

  assign serving = (state != ST_IDLE) && (txKind == KIND_MSG) && msgFromSlave;
  assign pollExp = (pollTo != '0) && (pollMs >= toMs(pollTo, 1'b1));
  assign statWr  = regWr && (regAddr == `HDPSL_OFS_STATUS);

  always_comb begin
    next_slvQueued  = slvQueued;
    next_pollMs     = pollMs;
    next_msgError   = msgError;
    next_msgTimeout = msgTimeout;
    if (statWr) begin
      next_msgError   = msgError   && !regWdata[`HDPSL_STAT_ERR];
      next_msgTimeout = msgTimeout && !regWdata[`HDPSL_STAT_TMO];
    end
    if (slvQueued && !serving) begin
      next_pollMs = pollMs + 21'(tick);
    end
    if (msgFromSlave && (msgAcked || msgUndeliverable)) begin
      next_slvQueued = 1'b0;
    end
    if (slvQueued && !serving && msgTimeoutHit) begin
      next_msgError   = 1'b1;
      next_msgTimeout = 1'b1;
      next_slvQueued  = 1'b0;
    end else if (slvQueued && !serving && pollExp) begin
      next_msgError  = 1'b1;
      next_slvQueued = 1'b0;
    end
    if (slvMsgReq && !slvQueued) begin
      next_slvQueued = 1'b1;
      next_pollMs    = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slvQueued  <= 1'b0;
      pollMs     <= '0;
      msgError   <= 1'b0;
      msgTimeout <= 1'b0;
    end else begin
      slvQueued  <= next_slvQueued;
      pollMs     <= next_pollMs;
      msgError   <= next_msgError;
      msgTimeout <= next_msgTimeout;
    end
  end

  // -----------------------------------------------------------------------
  // diagnostic counters
  // -----------------------------------------------------------------------
  logic [CNT_W-1:0] sentCnt, next_sentCnt;
  logic [CNT_W-1:0] rcvdCnt, next_rcvdCnt;
  logic [CNT_W-1:0] nakCnt,  next_nakCnt;
  logic [CNT_W-1:0] pollCnt, next_pollCnt;
  logic [CNT_W-1:0] nobufCnt, next_nobufCnt;
  logic             sentEv;

  assign sentEv = (state == ST_SEND) && txDone && (txKind == KIND_MSG);

  // counters wrap naturally at their width
  always_comb begin
    next_sentCnt  = sentCnt  + CNT_W'(sentEv);
    next_rcvdCnt  = rcvdCnt  + CNT_W'(rxGood);
    next_pollCnt  = pollCnt  + CNT_W'(pollHit);
    next_nakCnt   = nakCnt   + CNT_W'(rxNakValid);
    next_nobufCnt = nobufCnt + CNT_W'(rxMsgValid && addrOk && rxBufFull);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sentCnt  <= '0;
      rcvdCnt  <= '0;
      nakCnt   <= '0;
      pollCnt  <= '0;
      nobufCnt <= '0;
    end else begin
      sentCnt  <= next_sentCnt;
      rcvdCnt  <= next_rcvdCnt;
      nakCnt   <= next_nakCnt;
      pollCnt  <= next_pollCnt;
      nobufCnt <= next_nobufCnt;
    end
  end

  // -----------------------------------------------------------------------
  // read back
  // -----------------------------------------------------------------------
  logic [15:0] next_regRdata;

  always_comb begin
    next_regRdata = '0;
    if (regRd) begin
      unique case (regAddr)
        `HDPSL_OFS_CTRL:    next_regRdata = 16'(ctrl);
        `HDPSL_OFS_ADDR:    next_regRdata = 16'(stnAddr);
        `HDPSL_OFS_POLLTO:  next_regRdata = pollTo;
        `HDPSL_OFS_OFFDLY:  next_regRdata = offDly;
        `HDPSL_OFS_SENDDLY: next_regRdata = sendDly;
        `HDPSL_OFS_PREDLY:  next_regRdata = preDly;
        `HDPSL_OFS_RETRY:   next_regRdata = 16'(retries);
        `HDPSL_OFS_STATUS: begin
          next_regRdata[`HDPSL_STAT_ERR]    = msgError;
          next_regRdata[`HDPSL_STAT_TMO]    = msgTimeout;
          next_regRdata[`HDPSL_STAT_QUEUED] = slvQueued;
          next_regRdata[`HDPSL_STAT_RTS]    = rts;
          next_regRdata[`HDPSL_STAT_CTS]    = cts;
        end
        `HDPSL_OFS_SENT:    next_regRdata = 16'(sentCnt);
        `HDPSL_OFS_RCVD:    next_regRdata = 16'(rcvdCnt);
        `HDPSL_OFS_NAK:     next_regRdata = 16'(nakCnt);
        `HDPSL_OFS_POLLS:   next_regRdata = 16'(pollCnt);
        `HDPSL_OFS_NOBUF:   next_regRdata = 16'(nobufCnt);
        default:            next_regRdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule : hdpsl_link

// [dv/hdpsl_link_checker.sv]
// port assertions for the half-duplex polled slave link engine
`timescale 1ns/1ps

module hdpsl_checker (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic        rxMsgValid,
  input wire logic        rxBufFull,
  input wire logic        rxPollValid,
  input wire logic        rxAckValid,
  input wire logic        rxNakValid,
  input wire logic        msgTimeoutHit,
  input wire logic        cts,
  input wire logic        txDone,
  input wire logic        txEnable,
  input wire logic        rts,
  input wire logic        cmdExecute,
  input wire logic        msgAcked,
  input wire logic        msgUndeliverable,
  input wire logic        msgError,
  input wire logic        msgTimeout
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  chk_exec_cause: assert property (
    cmdExecute |-> $past(rxMsgValid) && !$past(rxBufFull))
    else $error("execute without a good message");
  chk_nobuf_block: assert property (
    rxMsgValid && rxBufFull |=> !cmdExecute)
    else $error("message executed with no buffer free");
  chk_send_cts: assert property (
    txEnable && rts |-> cts) else $error("sending while cts low");
  chk_rts_hold: assert property (
    txDone && rts |=> rts) else $error("rts dropped at last character");
  chk_ack_cause: assert property (
    msgAcked |-> $past(rxAckValid)) else $error("acked without ack");
  chk_give_up: assert property (
    msgUndeliverable |-> $past(rxNakValid) || $past(rxPollValid))
    else $error("undeliverable without nak or poll");
  chk_read_idle: assert property (
    !$past(regRd) |-> regRdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_tmo_cause: assert property (
    $rose(msgTimeout) |-> $past(msgTimeoutHit))
    else $error("timeout flag without timeout");
  chk_tmo_err: assert property (
    msgTimeout |-> msgError) else $error("timeout flag without error");

  cover property (cmdExecute);
  cover property (msgUndeliverable);
  cover property (txEnable && rts);
endmodule : hdpsl_checker

bind hdpsl_link hdpsl_checker hdpsl_checker_i (.*);

// [dv/hdpsl_master_model.sv]
// far side model: half-duplex modem and character serializer
`timescale 1ns/1ps

module hdpsl_master_model #(
  parameter int TX_LEN = 4
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic rts,
  input  wire logic txEnable,
  input  wire logic ctsLow,
  output logic      cts,
  output logic      txDone
);
  logic       rtsSeen;
  logic [7:0] charCnt;

  // ---------------------------------------------------------------------
  // modem grant and packet timing
  // ---------------------------------------------------------------------
  // the bench can hold the grant off to model a slow modem
  assign cts = rtsSeen && !ctsLow;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rtsSeen <= 1'b0;
      charCnt <= 8'h00;
      txDone  <= 1'b0;
    end else begin
      rtsSeen <= rts;
      txDone  <= txEnable && !txDone && charCnt == 8'(TX_LEN - 1);
      charCnt <= (!txEnable || txDone) ? 8'h00 : charCnt + 8'h01;
    end
  end
endmodule : hdpsl_master_model

// [dv/tb_hdpsl_link.sv]
// self-checking bench of the half-duplex polled slave link engine
`timescale 1ns/1ps

module tb_hdpsl_link;
  import hdpsl_pkg::*;
  localparam int TICK = 10;
  localparam int SLOW = 20 * TICK;
  logic        sys_clk, resetn, regWr, regRd, rxMsgValid, rxBufFull;
  logic        rxPollValid, rxAckValid, rxNakValid, replyReady, slvMsgReq;
  logic        msgTimeoutHit, cts, txDone, txEnable, rts, cmdExecute, ctsLow;
  logic        msgAcked, msgUndeliverable, msgFromSlave, msgError, msgTimeout;
  logic [7:0]  regAddr, rxMsgAddr, rxPollAddr;
  logic [15:0] regWdata, regRdata, rxMsgSig;
  hdpsl_kind_t txKind;
  int          failCount = 0;
  int          numChecks = 0;
  int          n;
  // register offset and value after reset
  logic [23:0] rows [14] = '{24'h000000, 24'h010001, 24'h020000, 24'h030000,
    24'h040000, 24'h050000, 24'h060003, 24'h070000, 24'h080000, 24'h0A0000,
    24'h0B0000, 24'h0E0000, 24'h0F0000, 24'h110000};

  hdpsl_link #(.TICK_CYCLES(TICK)) hdpsl_link_i (.*);
  hdpsl_master_model hdpsl_master_model_i (.sys_clk(sys_clk),
    .resetn(resetn), .rts(rts), .txEnable(txEnable), .ctsLow(ctsLow),
    .cts(cts), .txDone(txDone));

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic stopTest();
    $display("checks %0d, mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stopTest

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rdc

  // one-cycle event: 0 msg, 1 poll, 2 ack, 3 nak, 4 slave msg, 5 timeout
  task automatic ev(input int k);
    @(posedge sys_clk);
    case (k)
      0: rxMsgValid <= 1'b1;
      1: rxPollValid <= 1'b1;
      2: rxAckValid <= 1'b1;
      3: rxNakValid <= 1'b1;
      4: slvMsgReq <= 1'b1;
      default: msgTimeoutHit <= 1'b1;
    endcase
    @(posedge sys_clk);
    {rxMsgValid, rxPollValid, rxAckValid, rxNakValid} <= '0;
    {slvMsgReq, msgTimeoutHit} <= '0;
  endtask : ev

  function automatic logic cond(input int w);
    case (w)
      0: return rts;
      1: return txEnable;
      2: return !rts;
      3: return txDone;
      default: return msgError;
    endcase
  endfunction : cond

  // cycles until the condition holds, 1000 if it never does
  task automatic cnt(input int w, output int c);
    c = 0;
    #1;
    while (cond(w) !== 1'b1 && c < 1000) begin
      @(posedge sys_clk);
      #1 c++;
    end
  endtask : cnt

  task automatic waitTx(input hdpsl_kind_t k);
    int t;
    cnt(1, t);
    chk({t < 1000, txKind}, {1'b1, k});
    cnt(3, t);
    chk(t < 1000, 1'b1);
    repeat (3) @(posedge sys_clk);
  endtask : waitTx

  // ---------------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    failCount++;
    stopTest();
  end

  initial begin
    {regWr, regRd, rxMsgValid, rxBufFull, rxPollValid, rxAckValid} = '0;
    {rxNakValid, replyReady, slvMsgReq, msgTimeoutHit, ctsLow} = '0;
    {regAddr, regWdata, rxMsgSig} = '0;
    rxMsgAddr = 8'h01;
    rxPollAddr = 8'h01;
    resetn = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(8'h0A, 16'h5555);
    for (int i = 0; i < 14; i++) begin
      rdc(rows[i][23:16], rows[i][15:0]);
    end
    wr(8'h01, 16'h00FF);
    rdc(8'h01, 16'h0001);
    // same message three times, duplicate detect on for the last
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(8'h00, 16'h0001);
      rxMsgSig <= 16'h1234;
      ev(0);
      #1 chk(cmdExecute, i != 2);
      waitTx(KIND_ACK);
    end
    rxBufFull <= 1'b1;
    ev(0);
    #1 chk(cmdExecute, 1'b0);
    rxBufFull <= 1'b0;
    replyReady <= 1'b1;
    ev(1);
    waitTx(KIND_MSG);
    ev(2);
    #1 chk({msgAcked, msgFromSlave}, 2'b10);
    replyReady <= 1'b0;
    ev(4);
    repeat (50) @(posedge sys_clk);
    rdc(8'h07, 16'h0004);
    ev(1);
    waitTx(KIND_MSG);
    ev(2);
    #1 chk({msgAcked, msgFromSlave}, 2'b11);
    wr(8'h06, 16'h0001);
    ev(4);
    ev(1);
    for (int i = 0; i < 2; i++) begin
      waitTx(KIND_MSG);
      ev(3);
    end
    #1 chk(msgUndeliverable, 1'b1);
    wr(8'h02, 16'h0001);
    ev(4);
    cnt(4, n);
    chk(n >= SLOW - 15 && n <= SLOW + 15, 1'b1);
    rdc(8'h07, 16'h0001);
    wr(8'h07, 16'h0003);
    wr(8'h02, 16'h0000);
    ev(4);
    repeat (SLOW + 100) @(posedge sys_clk);
    #1 chk(msgError, 1'b0);
    ev(5);
    #1 chk({msgError, msgTimeout}, 2'b11);
    wr(8'h07, 16'h0003);
    ev(1);
    waitTx(KIND_EOT);
    wr(8'h00, 16'h0002);
    ev(1);
    cnt(1, n);
    chk(n == 1000, 1'b1);
    // broadcast is executed but never acknowledged
    rxMsgAddr <= 8'hFF;
    ev(0);
    #1 chk(cmdExecute, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1 chk(txEnable, 1'b0);
    rxMsgAddr <= 8'h01;
    // modem mode: pre 2 ms, send and off delay one 20 ms step each
    wr(8'h00, 16'h0004);
    wr(8'h05, 16'h0002);
    wr(8'h04, 16'h0001);
    wr(8'h03, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      ctsLow <= (p == 0);
      rxMsgSig <= p[0] ? 16'h0101 : 16'h0100;
      ev(0);
      cnt(0, n);
      chk(n >= TICK - 1 && n <= 2 * TICK + 6, 1'b1);
      if (p == 0) begin
        repeat (SLOW + 60) @(posedge sys_clk);
        #1 chk(txEnable, 1'b0);
        ctsLow <= 1'b0;
      end
      cnt(1, n);
      if (p == 1) chk(n >= SLOW - 15 && n <= SLOW + 15, 1'b1);
      cnt(3, n);
      cnt(2, n);
      chk(n >= SLOW - 15 && n <= SLOW + 15, 1'b1);
    end
    rdc(8'h0A, 16'h0004);
    rdc(8'h0B, 16'h0006);
    rdc(8'h0E, 16'h0002);
    rdc(8'h0F, 16'h0005);
    rdc(8'h11, 16'h0001);
    // a second reset in mid-run clears the counters
    resetn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(8'h0A, 16'h0000);
    rdc(8'h0B, 16'h0000);
    stopTest();
  end
endmodule : tb_hdpsl_link
